// File: logic/auto_wake_sleep_timing.sv
// auto wake/sleep timing: apb registers, sample period, inactivity timer
// assumes event flags are synchronous levels and buffer_flag_cleared a pulse
`timescale 1ns/1ps
module auto_wake_sleep_timing
  import aws_pkg::*;
#(
  parameter int STEP_CYC = STEP_CYCLES // shorten in simulation
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic change_outside_flag,
  input wire logic change_within_flag,
  input wire logic orientation_flag,
  input wire logic buffer_flag_cleared,
  output logic sleep_state,
  output logic sample_tick,
  output logic irq
);
  // ****************************************************************
  // register storage
  // ****************************************************************
  logic [7:0] wake_off_lo_ff; // wake off time bits 7:0
  logic [3:0] wake_off_hi_ff; // wake off time bits 11:8
  logic [7:0] sleep_off_lo_ff;
  logic [3:0] sleep_off_hi_ff;
  logic [7:0] inact_lo_ff; // inactivity count bits 7:0
  logic [3:0] inact_hi_ff; // inactivity count bits 11:8
  logic [PM_W-1:0] wake_power_select_ff;
  logic [PM_W-1:0] sleep_power_select_ff;
  logic [RATE_W-1:0] wake_rate_select_ff;
  logic [RATE_W-1:0] sleep_rate_select_ff;
  logic [DEC_W-1:0] wake_decimation_ff;
  logic [DEC_W-1:0] sleep_decimation_ff;
  logic [EV_W-1:0] event_src_ff; // event enables
  logic buffer_keeps_awake_ff;
  logic [IRQ_W-1:0] irq_status_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  pstate_t state_ff;

  // ****************************************************************
  // derived values
  // ****************************************************************
  logic [CNT_W-1:0] wake_offtime;
  logic [CNT_W-1:0] sleep_offtime;
  logic [CNT_W-1:0] inactivity_count;
  logic access; // apb access phase, first cycle
  logic wr_en;
  logic rd_en;
  logic [5:0] idx;
  logic mapped;
  logic [31:0] rd_mux;
  logic motion_event; // enabled wake-capable event
  logic buffer_event; // qualifying buffer flag clear
  logic activity; // restarts the inactivity timer
  logic feature_on;
  logic step_tick;
  logic period_tick;
  logic expire;
  logic [PER_W-1:0] period;
  logic [CNT_W-1:0] inact_value;
  logic [PM_W-1:0] cur_pm;
  logic [RATE_W-1:0] cur_rate;
  logic [DEC_W-1:0] cur_dec;
  logic [CNT_W-1:0] cur_off;
  logic go_sleep;
  logic go_wake;
  logic [IRQ_W-1:0] irq_set;

  assign wake_offtime = {wake_off_hi_ff, wake_off_lo_ff};
  assign sleep_offtime = {sleep_off_hi_ff, sleep_off_lo_ff};
  assign inactivity_count = {inact_hi_ff, inact_lo_ff};
  assign feature_on = (inactivity_count != '0);
  assign idx = paddr[7:2];
  assign access = psel && penable && !pready;
  assign wr_en = psel && penable && pready && pwrite && mapped; // lands as pready is sampled
  assign rd_en = access && !pwrite;

  // ****************************************************************
  // event qualification
  // ****************************************************************
  // only motion change and orientation wake; other sources have no input
  assign motion_event = (change_outside_flag && event_src_ff[EV_OUTSIDE])
    || (change_within_flag && event_src_ff[EV_WITHIN])
    || (orientation_flag && event_src_ff[EV_ORIENT]);
  // buffer clears only hold off sleep, never wake
  assign buffer_event = buffer_flag_cleared && buffer_keeps_awake_ff
    && event_src_ff[EV_BUFFER];
  assign activity = motion_event || buffer_event;
  assign go_sleep = (state_ff == ST_WAKE) && feature_on && expire && !motion_event;
  assign go_wake = (state_ff == ST_SLEEP) && (motion_event || !feature_on);

  // ****************************************************************
  // settings of the current state
  // ****************************************************************
  always_comb begin
    if (state_ff == ST_SLEEP) begin
      cur_pm = sleep_power_select_ff;
      cur_rate = sleep_rate_select_ff;
      cur_dec = sleep_decimation_ff;
      cur_off = sleep_offtime;
    end else begin
      cur_pm = wake_power_select_ff;
      cur_rate = wake_rate_select_ff;
      cur_dec = wake_decimation_ff;
      cur_off = wake_offtime;
    end
  end

  // ****************************************************************
  // timers
  // ****************************************************************
  // base step of 312.5 us, 62500 cycles at 200 MHz
  tick_counter #(.W(STEP_W)) u_step (
    .clk(clk),
    .sys_rst(sys_rst),
    .restart(1'b0),
    .advance(1'b1),
    .limit(STEP_W'(STEP_CYC)),
    .count_ff(),
    .tick_ff(step_tick)
  );

  period_select u_period (
    .clk(clk),
    .sys_rst(sys_rst),
    .power_select(cur_pm),
    .rate_select(cur_rate),
    .decimation(cur_dec),
    .offtime(cur_off),
    .period_ff(period)
  );

  // sample period restarts with each change of power state
  tick_counter #(.W(PER_W)) u_sample (
    .clk(clk),
    .sys_rst(sys_rst),
    .restart(go_sleep || go_wake),
    .advance(step_tick),
    .limit(period),
    .count_ff(),
    .tick_ff(period_tick)
  );

  // inactivity timer counts wake periods only
  tick_counter #(.W(CNT_W)) u_inact (
    .clk(clk),
    .sys_rst(sys_rst),
    .restart(activity || (state_ff == ST_SLEEP) || !feature_on),
    .advance(period_tick && (state_ff == ST_WAKE)),
    .limit(inactivity_count),
    .count_ff(inact_value),
    .tick_ff(expire)
  );

  // ****************************************************************
  // power state
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_WAKE;
    end else begin
      case (state_ff)
        ST_WAKE: begin
          if (go_sleep) begin
            state_ff <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (go_wake) begin
            state_ff <= ST_WAKE;
          end
        end
        default: begin
          state_ff <= ST_WAKE;
        end
      endcase
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  // high bytes keep only the low nibble, so upper bits stay zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_off_lo_ff <= BYTE_RESET;
      wake_off_hi_ff <= BYTE_RESET[3:0];
      sleep_off_lo_ff <= BYTE_RESET;
      sleep_off_hi_ff <= BYTE_RESET[3:0];
      inact_lo_ff <= BYTE_RESET;
      inact_hi_ff <= BYTE_RESET[3:0];
      wake_power_select_ff <= '0;
      sleep_power_select_ff <= '0;
      wake_rate_select_ff <= '0;
      sleep_rate_select_ff <= '0;
      wake_decimation_ff <= '0;
      sleep_decimation_ff <= '0;
      event_src_ff <= '0;
      buffer_keeps_awake_ff <= 1'b0;
      irq_mask_ff <= '0;
    end else if (wr_en) begin
      case (idx)
        IDX_WAKE_OFF_LO: wake_off_lo_ff <= pwdata[7:0];
        IDX_WAKE_OFF_HI: wake_off_hi_ff <= pwdata[3:0];
        IDX_SLEEP_OFF_LO: sleep_off_lo_ff <= pwdata[7:0];
        IDX_SLEEP_OFF_HI: sleep_off_hi_ff <= pwdata[3:0];
        IDX_INACT_LO: inact_lo_ff <= pwdata[7:0];
        IDX_INACT_HI: inact_hi_ff <= pwdata[3:0];
        IDX_POWER_MODE: begin
          wake_power_select_ff <= pwdata[1:0];
          sleep_power_select_ff <= pwdata[3:2];
        end
        IDX_RATE: begin
          wake_rate_select_ff <= pwdata[3:0];
          sleep_rate_select_ff <= pwdata[7:4];
        end
        IDX_DECIMATION: begin
          wake_decimation_ff <= pwdata[2:0];
          sleep_decimation_ff <= pwdata[6:4];
        end
        IDX_EVENT_SRC: event_src_ff <= pwdata[EV_W-1:0];
        IDX_BUF_CFG: buffer_keeps_awake_ff <= pwdata[0];
        IDX_IRQ_MASK: irq_mask_ff <= pwdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // interrupt status, write one to clear, a new event wins
  // ****************************************************************
  assign irq_set = {go_wake, go_sleep};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status_ff <= '0;
    end else if (wr_en && (idx == IDX_IRQ_STATUS)) begin
      irq_status_ff <= (irq_status_ff & ~pwdata[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status_ff <= irq_status_ff | irq_set;
    end
  end

  // one-cycle lag keeps irq straight from a flip-flop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_ff & irq_mask_ff);
    end
  end

  // ****************************************************************
  // read mux and apb answer
  // ****************************************************************
  always_comb begin
    rd_mux = '0;
    mapped = 1'b1;
    case (idx)
      IDX_WAKE_OFF_LO: rd_mux[7:0] = wake_off_lo_ff;
      IDX_WAKE_OFF_HI: rd_mux[3:0] = wake_off_hi_ff;
      IDX_SLEEP_OFF_LO: rd_mux[7:0] = sleep_off_lo_ff;
      IDX_SLEEP_OFF_HI: rd_mux[3:0] = sleep_off_hi_ff;
      IDX_INACT_LO: rd_mux[7:0] = inact_lo_ff;
      IDX_INACT_HI: rd_mux[3:0] = inact_hi_ff;
      IDX_POWER_MODE: rd_mux[3:0] = {sleep_power_select_ff, wake_power_select_ff};
      IDX_RATE: rd_mux[7:0] = {sleep_rate_select_ff, wake_rate_select_ff};
      IDX_DECIMATION: rd_mux[6:0] = {sleep_decimation_ff, 1'b0, wake_decimation_ff};
      IDX_EVENT_SRC: rd_mux[EV_W-1:0] = event_src_ff;
      IDX_BUF_CFG: rd_mux[0] = buffer_keeps_awake_ff;
      IDX_STATUS: begin
        rd_mux[CNT_W-1:0] = inact_value; // running inactivity count
        rd_mux[STAT_SLEEP] = (state_ff == ST_SLEEP);
      end
      IDX_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_status_ff;
      IDX_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_ff;
      default: mapped = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0; // misaligned address is refused
      rd_mux = '0;
    end
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= access;
      pslverr <= access && !mapped;
      prdata <= (rd_en && mapped) ? rd_mux : '0;
    end
  end

  // state and tick outputs straight from flip-flops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_state <= 1'b0;
      sample_tick <= 1'b0;
    end else begin
      sleep_state <= go_sleep || ((state_ff == ST_SLEEP) && !go_wake);
      sample_tick <= period_tick;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_expiry;
    (state_ff == ST_WAKE) && feature_on && expire && !motion_event;
  endsequence

  property p_enter_sleep;
    @(posedge clk) disable iff (sys_rst) s_expiry |=> (state_ff == ST_SLEEP) && sleep_state;
  endproperty
  a_enter_sleep: assert property (p_enter_sleep) else $error("no sleep on expiry");

  property p_wake_now;
    @(posedge clk) disable iff (sys_rst)
      (state_ff == ST_SLEEP) && motion_event |=> (state_ff == ST_WAKE);
  endproperty
  a_wake_now: assert property (p_wake_now) else $error("event did not wake");

  property p_disabled;
    @(posedge clk) disable iff (sys_rst) !feature_on |=> (state_ff == ST_WAKE);
  endproperty
  a_disabled: assert property (p_disabled) else $error("sleep with zero count");

  property p_restart;
    @(posedge clk) disable iff (sys_rst) activity |=> (inact_value == '0) && !expire;
  endproperty
  a_restart: assert property (p_restart) else $error("timer not restarted");

  property p_buffer_no_wake;
    @(posedge clk) disable iff (sys_rst)
      (state_ff == ST_SLEEP) && !motion_event && feature_on |=> (state_ff == ST_SLEEP);
  endproperty
  a_buffer_no_wake: assert property (p_buffer_no_wake) else $error("woke without event");

  property p_count_wake_only;
    @(posedge clk) disable iff (sys_rst)
      (state_ff == ST_SLEEP) ##1 (state_ff == ST_SLEEP) |-> (inact_value == '0);
  endproperty
  a_count_wake_only: assert property (p_count_wake_only) else $error("counted in sleep");

  property p_flex_period;
    @(posedge clk) disable iff (sys_rst)
      cur_pm[PM_FLEX_BIT] |=> period == PER_W'($past(cur_off)) + (PER_W'(1) << $past(cur_dec));
  endproperty
  a_flex_period: assert property (p_flex_period) else $error("bad flexible period");

  property p_fixed_period;
    @(posedge clk) disable iff (sys_rst)
      !cur_pm[PM_FLEX_BIT] && (cur_rate <= RATE_SLOWEST)
      |=> period == (PER_W'(1) << $past(cur_rate));
  endproperty
  a_fixed_period: assert property (p_fixed_period) else $error("off time not ignored");

  property p_high_nibble;
    @(posedge clk) disable iff (sys_rst)
      rd_en && mapped && (idx == IDX_INACT_HI || idx == IDX_WAKE_OFF_HI)
      |=> pready && (prdata[7:4] == 4'h0);
  endproperty
  a_high_nibble: assert property (p_high_nibble) else $error("high nibble nonzero");
endmodule : auto_wake_sleep_timing

// File: logic/aws_pkg.sv
// constants, types and register map of the auto wake/sleep timing block
// assumes a single 200 MHz clock and a 32-bit apb master in front of it
//
// Operation
// - wake off time is twelve bits, two bytes
// - one off-time count lasts 312.5 microseconds
// - wake off time counts only in flexible mode
// - flexible period is off time plus measurement
// - sleep off time built alike, flexible only
// - inactivity count sets periods before entering sleep
// - inactivity count is twelve bits, two bytes
// - inactivity counter steps once per wake period
// - zero inactivity count disables auto switching
// - wake and sleep use separate setting sets
// - enabled events wake device, buffer flag excepted
// - enabled event in sleep wakes at once
// - at 3200 Hz a step is 0.3125 ms
// - only motion-change and orientation events count
// - buffer flag restarts timer only when option set
package aws_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 5000; // 200 MHz
  localparam int STEP_TIME_PS = 312500000; // 312.5 us off-time step
  // least time rounds up to whole cycles
  localparam int STEP_CYCLES = (STEP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STEP_W = 17; // holds STEP_CYCLES
  localparam int CNT_W = 12; // off time and inactivity widths
  localparam int PER_W = 14; // sample period in steps
  localparam int RATE_W = 4;
  localparam int DEC_W = 3;
  localparam int PM_W = 2;
  localparam logic [RATE_W-1:0] RATE_SLOWEST = 4'hc; // 4096 steps
  localparam int PM_FLEX_BIT = 1; // pattern 1x selects flexible mode

  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [5:0] IDX_WAKE_OFF_LO = 6'h1a;
  localparam logic [5:0] IDX_WAKE_OFF_HI = 6'h1b;
  localparam logic [5:0] IDX_SLEEP_OFF_LO = 6'h1c;
  localparam logic [5:0] IDX_SLEEP_OFF_HI = 6'h1d;
  localparam logic [5:0] IDX_INACT_LO = 6'h1e;
  localparam logic [5:0] IDX_INACT_HI = 6'h1f;
  localparam logic [5:0] IDX_POWER_MODE = 6'h30;
  localparam logic [5:0] IDX_RATE = 6'h31;
  localparam logic [5:0] IDX_DECIMATION = 6'h32;
  localparam logic [5:0] IDX_EVENT_SRC = 6'h33;
  localparam logic [5:0] IDX_BUF_CFG = 6'h34;
  localparam logic [5:0] IDX_STATUS = 6'h35;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h36;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h37;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // event_source_config bits
  localparam int EV_OUTSIDE = 0;
  localparam int EV_WITHIN = 1;
  localparam int EV_ORIENT = 2;
  localparam int EV_BUFFER = 3;
  localparam int EV_W = 4;
  // status bits
  localparam int STAT_SLEEP = 12;
  // interrupt bits
  localparam int IRQ_SLEEP = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_W = 2;

  typedef enum logic {ST_WAKE, ST_SLEEP} pstate_t;
endpackage : aws_pkg

// File: logic/tick_counter.sv
// wrap counter that pulses once every limit advances
// assumes limit of zero means stopped
`timescale 1ns/1ps
module tick_counter
  import aws_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic restart,
  input wire logic advance,
  input wire logic [W-1:0] limit,
  output logic [W-1:0] count_ff,
  output logic tick_ff
);
  // ****************************************************************
  // count and pulse
  // ****************************************************************
  // >= catches a limit lowered below the running count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_ff <= '0;
      tick_ff <= 1'b0;
    end else if (restart) begin
      count_ff <= '0;
      tick_ff <= 1'b0;
    end else if (advance && (limit != '0) && (count_ff >= limit - 1'b1)) begin
      count_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      count_ff <= count_ff + W'(advance && (limit != '0));
      tick_ff <= 1'b0;
    end
  end
endmodule : tick_counter

// File: logic/period_select.sv
// turns one power state's settings into a sample period in off-time steps
// assumes the settings given are those of the current state
`timescale 1ns/1ps
module period_select
  import aws_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [PM_W-1:0] power_select,
  input wire logic [RATE_W-1:0] rate_select,
  input wire logic [DEC_W-1:0] decimation,
  input wire logic [CNT_W-1:0] offtime,
  output logic [PER_W-1:0] period_ff
);
  logic [RATE_W-1:0] rate_lim; // clamped rate code

  assign rate_lim = (rate_select > RATE_SLOWEST) ? RATE_SLOWEST : rate_select;

  // ****************************************************************
  // period register
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      period_ff <= '0;
    end else if (power_select[PM_FLEX_BIT]) begin
      // off time plus measurement time of the decimation
      period_ff <= PER_W'(offtime) + (PER_W'(1) << decimation);
    end else begin
      // fixed rate, off time ignored; rate code 0 is one step
      period_ff <= PER_W'(1) << rate_lim;
    end
  end
endmodule : period_select

// File: sim/testbench.sv
// self-checking bench for the auto wake/sleep timing block
// assumes the block answers apb in two access cycles and is built with a short off-time step
`timescale 1ns/1ps
module testbench;
  import aws_pkg::*;
  // ****************************************************************
  // clock, reset and design inputs
  // ****************************************************************
  localparam int STEP = 4; // cycles per off-time step, short for a quick run
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic change_outside_flag = 1'b0;
  logic change_within_flag = 1'b0;
  logic orientation_flag = 1'b0;
  logic buffer_flag_cleared = 1'b0;
  logic sleep_state;
  logic sample_tick;
  logic irq;
  int mismatches = 0;
  int total_checks = 0;
  int ticks;
  int gap;

  auto_wake_sleep_timing #(.STEP_CYC(STEP)) dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .change_outside_flag(change_outside_flag),
    .change_within_flag(change_within_flag), .orientation_flag(orientation_flag),
    .buffer_flag_cleared(buffer_flag_cleared), .sleep_state(sleep_state),
    .sample_tick(sample_tick), .irq(irq));

  // free-running 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  // ****************************************************************
  // reporting
  // ****************************************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    // case inequality so an unknown never matches
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // a wait in apb, wait_tick or wait_sleep that runs out of its bound ends the run
  task automatic fail(input string what);
    mismatches++;
    $display("unexpected at %0t: %s", $time, what);
    conclude();
  endtask : fail

  // ****************************************************************
  // apb master: hold the request until pready is seen, release after that edge
  // ****************************************************************
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // pready is read at the rising edge, before that edge's own updates land
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fail("no pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, wd, rd, err);
    check(err, 0, "write error");
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input logic exp_err);
    logic [31:0] d;
    logic err;
    apb(1'b0, idx, 32'h00000000, d, err);
    check(err, exp_err, "read error flag");
    check(d, exp, "read data");
  endtask : rd

  // ****************************************************************
  // timing helpers, all bounded
  // ****************************************************************
  task automatic wait_tick();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sample_tick !== 1'b1 && n < 3000);
    if (sample_tick !== 1'b1) fail("no sample tick");
  endtask : wait_tick

  // skip one period so a fresh setting has landed, then time the next
  task automatic period(output int g);
    wait_tick();
    wait_tick();
    g = 0;
    do begin
      @(negedge clk);
      g++;
    end while (sample_tick !== 1'b1 && g < 3000);
  endtask : period

  task automatic wait_sleep(input logic lvl, input int bound);
    int n;
    n = 0;
    while (sleep_state !== lvl && n < bound) begin
      @(negedge clk);
      n++;
    end
    if (sleep_state !== lvl) fail("sleep state not reached");
  endtask : wait_sleep

  task automatic cfg_period(input logic [7:0] pm, input logic [7:0] rate, input logic [7:0] dec,
                            input logic [7:0] lo, input logic [7:0] hi, input int exp);
    wr(IDX_POWER_MODE, {24'h000000, pm});
    wr(IDX_RATE, {24'h000000, rate});
    wr(IDX_DECIMATION, {24'h000000, dec});
    wr(IDX_WAKE_OFF_LO, {24'h000000, lo});
    wr(IDX_WAKE_OFF_HI, {24'h000000, hi});
    period(gap);
    check(gap, exp, "sample period");
  endtask : cfg_period

  // host clears the buffer flag every seven cycles, faster than the timeout
  task automatic buf_pulses();
    repeat (8) begin
      repeat (6) @(posedge clk);
      buffer_flag_cleared <= 1'b1;
      @(posedge clk);
      buffer_flag_cleared <= 1'b0;
    end
  endtask : buf_pulses

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values and loose upper bits
    for (int i = 0; i < 6; i++) begin
      rd(IDX_WAKE_OFF_LO + i[5:0], 32'h00000000, 1'b0);
    end
    check(sleep_state, 0, "sleep after reset");
    for (int i = 0; i < 6; i++) begin
      wr(IDX_WAKE_OFF_LO + i[5:0], 32'h000000f0 | i);
      rd(IDX_WAKE_OFF_LO + i[5:0], i[0] ? 32'h00000000 | i : 32'h000000f0 | i, 1'b0);
      wr(IDX_WAKE_OFF_LO + i[5:0], 32'h00000000);
    end
    rd(6'h20, 32'h00000000, 1'b1); // unmapped place answers with an error
    $display("test registers done");
    // sample periods in steps of STEP cycles
    cfg_period(8'h00, 8'h00, 8'h00, 8'h03, 8'h00, STEP);
    cfg_period(8'h01, 8'h02, 8'h00, 8'h03, 8'h00, 4 * STEP);
    cfg_period(8'h02, 8'h05, 8'h01, 8'h03, 8'h00, 5 * STEP);
    cfg_period(8'h03, 8'h00, 8'h00, 8'h00, 8'h01, 257 * STEP);
    $display("test periods done");
    // auto-sleep after three quiet wake periods
    cfg_period(8'h08, 8'h20, 8'h00, 8'h00, 8'h00, STEP);
    wr(IDX_SLEEP_OFF_LO, 32'h00000005);
    wr(IDX_EVENT_SRC, 32'h00000001);
    wr(IDX_IRQ_MASK, 32'h00000001);
    wr(IDX_INACT_LO, 32'h00000003);
    @(posedge clk);
    change_outside_flag <= 1'b1;
    @(posedge clk);
    change_outside_flag <= 1'b0;
    // a tick at the restart edge is discarded by the design, so skip it here too
    @(posedge clk);
    ticks = 0;
    for (int n = 0; n < 400 && sleep_state !== 1'b1; n++) begin
      @(negedge clk);
      if (sample_tick === 1'b1 && sleep_state !== 1'b1) ticks++;
    end
    check(sleep_state, 1, "entered sleep");
    check(ticks, 3, "quiet periods before sleep");
    rd(IDX_STATUS, 32'h00001000, 1'b0);
    check(irq, 1, "sleep interrupt");
    rd(IDX_IRQ_STATUS, 32'h00000001, 1'b0);
    period(gap);
    check(gap, 6 * STEP, "sleep period");
    wr(IDX_IRQ_STATUS, 32'h00000001);
    repeat (2) @(negedge clk);
    check(irq, 0, "interrupt cleared");
    $display("test sleep entry done");
    // disabled event and buffer clear keep sleep, enabled orientation wakes at once
    @(posedge clk);
    change_within_flag <= 1'b1;
    buffer_flag_cleared <= 1'b1;
    @(posedge clk);
    buffer_flag_cleared <= 1'b0;
    repeat (20) @(posedge clk);
    change_within_flag <= 1'b0;
    check(sleep_state, 1, "no wake from disabled sources");
    wr(IDX_EVENT_SRC, 32'h00000005);
    @(posedge clk);
    orientation_flag <= 1'b1;
    @(posedge clk);
    orientation_flag <= 1'b0;
    @(negedge clk);
    check(sleep_state, 0, "orientation wakes");
    rd(IDX_IRQ_STATUS, 32'h00000002, 1'b0);
    check(irq, 0, "masked wake interrupt");
    wr(IDX_IRQ_STATUS, 32'h00000002);
    $display("test wake done");
    // buffer clears hold wake only with the option set
    wr(IDX_EVENT_SRC, 32'h00000009);
    wr(IDX_BUF_CFG, 32'h00000001);
    // an enabled motion pulse returns to wake and restarts the timer
    @(posedge clk);
    change_outside_flag <= 1'b1;
    @(posedge clk);
    change_outside_flag <= 1'b0;
    buf_pulses();
    check(sleep_state, 0, "buffer clears hold wake");
    wr(IDX_BUF_CFG, 32'h00000000);
    buf_pulses();
    check(sleep_state, 1, "buffer clears ignored");
    $display("test buffer done");
    // zero count switches the feature off
    wr(IDX_INACT_LO, 32'h00000000);
    wait_sleep(1'b0, 20);
    repeat (100) @(negedge clk);
    check(sleep_state, 0, "no sleep with zero count");
    $display("test zero count done");
    conclude();
  end
endmodule : testbench
